// ==== common/rslc_pkg.sv ====
// Constants, reset values and types for the reset-state and lock-check block
// Contract
// R1 - Extra segments reset: selector 0, base 0, limit FFFF
// R2 - Interrupt table pointer reset: base 0, limit 3FF
// R3 - Machine status 60000010h, control four zero
// R4 - Config controls zero, config four 80h
// R5 - Eight address region registers cleared
// R6 - Eight region controls cleared, weak lock off
// R7 - Debug control register reset to 00000400h
// R8 - Two identification registers hold codes
// R9 - Locked read-modify-write asserts bus lock
// R10 - Lock accepted only on listed groups
// R11 - Lock elsewhere raises invalid opcode
// R12 - Lock with register destination invalid
// R13 - Global or region weak lock negates lock
// R14 - Zero to three operands supported
// R15 - Operand lengths 8,16,32 and 64,80
// R16 - Prefix overrides default operand length
// R17 - Immediate fetched with opcode bytes
// R18 - Reset halts activity, real mode, cache off
// R19 - Fetch starts 150-250 clocks after reset
// R20 - Identification registers are read-only
package rslc_pkg;
    localparam int ADDR_W = 6;
    // Register index map
    localparam logic [5:0] A_FSEL   = 6'h00;
    localparam logic [5:0] A_FBASE  = 6'h01;
    localparam logic [5:0] A_FLIM   = 6'h02;
    localparam logic [5:0] A_GSEL   = 6'h03;
    localparam logic [5:0] A_GBASE  = 6'h04;
    localparam logic [5:0] A_GLIM   = 6'h05;
    localparam logic [5:0] A_IBASE  = 6'h06;
    localparam logic [5:0] A_ILIM   = 6'h07;
    localparam logic [5:0] A_MSC    = 6'h08;
    localparam logic [5:0] A_CTRL4  = 6'h09;
    localparam logic [5:0] A_DBG    = 6'h0A;
    localparam logic [5:0] A_ID0    = 6'h0B;
    localparam logic [5:0] A_ID1    = 6'h0C;
    localparam logic [5:0] A_STAT   = 6'h0D;
    localparam logic [5:0] A_CCR    = 6'h10;
    localparam logic [5:0] A_REGION = 6'h18;
    localparam logic [5:0] A_RCR    = 6'h20;
    localparam logic [5:0] A_BANK_M = 6'h38;
    // Reset values
    localparam logic [15:0] SEG_SEL_RST  = 16'h0000;
    localparam logic [31:0] SEG_BASE_RST = 32'h0000_0000;
    localparam logic [15:0] SEG_LIM_RST  = 16'hFFFF;
    localparam logic [31:0] IDT_BASE_RST = 32'h0000_0000;
    localparam logic [15:0] IDT_LIM_RST  = 16'h03FF;
    localparam logic [31:0] MSC_RST      = 32'h6000_0010;
    localparam logic [31:0] CTRL4_RST    = 32'h0000_0000;
    localparam logic [7:0]  CCR_RST      = 8'h00;
    localparam logic [7:0]  CFG4_RST     = 8'h80;
    localparam logic [7:0]  REGION_RST   = 8'h00;
    localparam logic [7:0]  RCR_RST      = 8'h00;
    localparam logic [31:0] DBG_RST      = 32'h0000_0400;
    localparam logic [2:0]  CFG4_IDX     = 3'h4;
    localparam logic [2:0]  CFG1_IDX     = 3'h1;
    // Field positions
    localparam int NO_LOCK_BIT   = 4;
    localparam int WEAK_LOCK_BIT = 6;
    localparam int MSC_PE_BIT  = 0;
    localparam int MSC_PG_BIT  = 31;
    localparam int MSC_CD_BIT  = 30;
    // Fetch start
    localparam logic [31:0] FETCH_VECTOR = 32'hFFFF_FFF0;
    localparam int START_CLKS            = 200;
    // Opcode classes presented by the decoder front end
    typedef enum logic [2:0] {
        RSLC_OP_BITTEST,
        RSLC_OP_XCHG,
        RSLC_OP_UNARY,
        RSLC_OP_BINARY,
        RSLC_OP_OTHER
    } rslc_opclass_t;
    // Operand length codes
    typedef enum logic [2:0] {
        RSLC_LEN_8,
        RSLC_LEN_16,
        RSLC_LEN_32,
        RSLC_LEN_64,
        RSLC_LEN_80
    } rslc_len_t;
endpackage

// ==== rtl/rslc_lock_check.sv ====
// Lock-prefix legality, operand length and lock drive decision
module rslc_lock_check (
    input  wire logic                   clk,
    input  wire logic                   rstSync_n,
    input  wire logic                   decValid,
    input  wire rslc_pkg::rslc_opclass_t opClass,
    input  wire logic                   lockPrefix,
    input  wire logic                   destIsMem,
    input  wire logic                   sizePrefix,
    input  wire logic                   code32,
    input  wire logic                   byteOp,
    input  wire logic                   fpOp,
    input  wire logic                   fpExt,
    input  wire logic [1:0]             numOps,
    input  wire logic                   noLockGlobal,
    input  wire logic                   regionWeak,
    output logic                        invOpcode,
    output logic                        lockOut,
    output rslc_pkg::rslc_len_t         opLen,
    output logic [1:0]                  opCount
);
    logic groupOk;
    logic badLock;
    logic wantLock;
    logic wide32;
    rslc_pkg::rslc_len_t next_opLen;

    assign groupOk = (opClass != rslc_pkg::RSLC_OP_OTHER); // R10
    assign badLock = decValid && lockPrefix && (!groupOk || !destIsMem); // R11 R12
    assign wantLock = decValid && lockPrefix && groupOk && destIsMem; // R9
    // Size prefix flips the default width
    assign wide32 = code32 ^ sizePrefix; // R16
    assign next_opLen = fpOp ? (fpExt ? rslc_pkg::RSLC_LEN_80 : rslc_pkg::RSLC_LEN_64)
                      : byteOp ? rslc_pkg::RSLC_LEN_8
                      : wide32 ? rslc_pkg::RSLC_LEN_32 : rslc_pkg::RSLC_LEN_16; // R15

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            invOpcode <= 1'b0;
            lockOut   <= 1'b0;
            opLen     <= rslc_pkg::RSLC_LEN_16;
            opCount   <= 2'd0;
        end else begin
            invOpcode <= badLock;
            lockOut   <= wantLock && !noLockGlobal && !regionWeak; // R13
            if (decValid) begin
                opLen   <= next_opLen;
                opCount <= numOps; // R14
            end
        end
    end

    AST_BAD_LOCK: assert property (@(posedge clk) disable iff (!rstSync_n)
        decValid && lockPrefix && !destIsMem |=> invOpcode && !lockOut) // R12
        else $error("register destination lock not refused");
    AST_OTHER_LOCK: assert property (@(posedge clk) disable iff (!rstSync_n)
        decValid && lockPrefix && opClass == rslc_pkg::RSLC_OP_OTHER |=> invOpcode) // R11
        else $error("lock on other group not refused");
    AST_WEAK: assert property (@(posedge clk) disable iff (!rstSync_n)
        (noLockGlobal || regionWeak) |=> !lockOut) // R13
        else $error("lock driven under weak locking");
    AST_LOCK_ON: assert property (@(posedge clk) disable iff (!rstSync_n)
        wantLock && !noLockGlobal && !regionWeak |=> lockOut && !invOpcode) // R9
        else $error("valid locked op did not lock");
endmodule

// ==== rtl/rslc_reset_state.sv ====
// Architectural reset state registers with lock-prefix checking
module rslc_reset_state #(
    parameter int                    START_DELAY = rslc_pkg::START_CLKS,
    parameter logic [7:0]            DEV_CODE    = 8'hC4, // Arbitrary value
    parameter logic [7:0]            STEP_REV    = 8'h21  // Arbitrary value
) (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic [5:0]             regAddr,
    input  wire logic [31:0]            regWdata,
    input  wire logic                   regWr,
    input  wire logic                   regRd,
    output logic [31:0]                 regRdata,
    input  wire logic                   decValid,
    input  wire rslc_pkg::rslc_opclass_t opClass,
    input  wire logic                   lockPrefix,
    input  wire logic                   destIsMem,
    input  wire logic [2:0]             memRegion,
    input  wire logic                   sizePrefix,
    input  wire logic                   byteOp,
    input  wire logic                   fpOp,
    input  wire logic                   fpExt,
    input  wire logic [1:0]             numOps,
    input  wire logic                   prefetchImm,
    output logic                        invOpcode,
    output logic                        busLock,
    output rslc_pkg::rslc_len_t         opLen,
    output logic [1:0]                  opCount,
    output logic                        immFromPrefetch,
    output logic                        fetchStart,
    output logic [31:0]                 fetchAddr,
    output logic                        coreRun
);
    initial begin
        if (START_DELAY < 1 || START_DELAY > 1023) $error("START_DELAY out of range");
    end

    logic        rstMeta_n;
    logic        rstSync_n;
    logic [15:0] fSel;
    logic [31:0] fBase;
    logic [15:0] fLim;
    logic [15:0] gSel;
    logic [31:0] gBase;
    logic [15:0] gLim;
    logic [31:0] idtBase;
    logic [15:0] idtLim;
    logic [31:0] msc;
    logic [31:0] ctrlFour;
    logic [31:0] dbg;
    logic [7:0]  ccr [0:7];
    logic [7:0]  regionAddr [0:7];
    logic [7:0]  rcr [0:7];
    logic [9:0]  startCnt;
    logic [31:0] next_rdata;
    logic        inCcr;
    logic        inRegion;
    logic        inRcr;
    logic [2:0]  idx;
    logic        code32;
    logic        lockRaw;

    function automatic logic wrHit(input logic [5:0] a, input logic [5:0] want);
        return a == want;
    endfunction

    // Reset is asserted asynchronously, released via two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_n <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstMeta_n <= 1'b1;
            rstSync_n <= rstMeta_n;
        end
    end

    assign idx   = regAddr[2:0];
    assign inCcr = (regAddr & rslc_pkg::A_BANK_M) == rslc_pkg::A_CCR;
    assign inRegion = (regAddr & rslc_pkg::A_BANK_M) == rslc_pkg::A_REGION;
    assign inRcr = (regAddr & rslc_pkg::A_BANK_M) == rslc_pkg::A_RCR;
    assign code32 = msc[rslc_pkg::MSC_PE_BIT];

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            fSel    <= rslc_pkg::SEG_SEL_RST;  // R1
            fBase   <= rslc_pkg::SEG_BASE_RST; // R1
            fLim    <= rslc_pkg::SEG_LIM_RST;  // R1
            gSel    <= rslc_pkg::SEG_SEL_RST;  // R1
            gBase   <= rslc_pkg::SEG_BASE_RST; // R1
            gLim    <= rslc_pkg::SEG_LIM_RST;  // R1
            idtBase <= rslc_pkg::IDT_BASE_RST; // R2
            idtLim  <= rslc_pkg::IDT_LIM_RST;  // R2
            msc     <= rslc_pkg::MSC_RST;      // R3 R18
            ctrlFour <= rslc_pkg::CTRL4_RST;   // R3
            dbg     <= rslc_pkg::DBG_RST;      // R7
        end else if (regWr) begin
            if (wrHit(regAddr, rslc_pkg::A_FSEL))  fSel    <= regWdata[15:0];
            if (wrHit(regAddr, rslc_pkg::A_FBASE)) fBase   <= regWdata;
            if (wrHit(regAddr, rslc_pkg::A_FLIM))  fLim    <= regWdata[15:0];
            if (wrHit(regAddr, rslc_pkg::A_GSEL))  gSel    <= regWdata[15:0];
            if (wrHit(regAddr, rslc_pkg::A_GBASE)) gBase   <= regWdata;
            if (wrHit(regAddr, rslc_pkg::A_GLIM))  gLim    <= regWdata[15:0];
            if (wrHit(regAddr, rslc_pkg::A_IBASE)) idtBase <= regWdata;
            if (wrHit(regAddr, rslc_pkg::A_ILIM))  idtLim  <= regWdata[15:0];
            if (wrHit(regAddr, rslc_pkg::A_MSC))   msc     <= regWdata;
            if (wrHit(regAddr, rslc_pkg::A_CTRL4)) ctrlFour <= regWdata;
            if (wrHit(regAddr, rslc_pkg::A_DBG))   dbg     <= regWdata;
        end
    end

    // Banks of eight byte registers; config register 7 ignores writes and reads as zero
    for (genvar i = 0; i < 8; i++) begin : g_bank
        always_ff @(posedge clk or negedge rstSync_n) begin
            if (!rstSync_n) begin
                ccr[i] <= (i == rslc_pkg::CFG4_IDX) ? rslc_pkg::CFG4_RST
                                                   : rslc_pkg::CCR_RST; // R4
                regionAddr[i] <= rslc_pkg::REGION_RST; // R5
                rcr[i] <= rslc_pkg::RCR_RST; // R6
            end else if (regWr && idx == 3'(i)) begin
                if (inCcr && i < 7) ccr[i] <= regWdata[7:0];
                if (inRegion) regionAddr[i] <= regWdata[7:0];
                if (inRcr) rcr[i] <= regWdata[7:0];
            end
        end
    end

    // Identification codes are constants; writes fall on nothing
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (1'b1)
            wrHit(regAddr, rslc_pkg::A_FSEL):  next_rdata = {16'h0000, fSel};
            wrHit(regAddr, rslc_pkg::A_FBASE): next_rdata = fBase;
            wrHit(regAddr, rslc_pkg::A_FLIM):  next_rdata = {16'h0000, fLim};
            wrHit(regAddr, rslc_pkg::A_GSEL):  next_rdata = {16'h0000, gSel};
            wrHit(regAddr, rslc_pkg::A_GBASE): next_rdata = gBase;
            wrHit(regAddr, rslc_pkg::A_GLIM):  next_rdata = {16'h0000, gLim};
            wrHit(regAddr, rslc_pkg::A_IBASE): next_rdata = idtBase;
            wrHit(regAddr, rslc_pkg::A_ILIM):  next_rdata = {16'h0000, idtLim};
            wrHit(regAddr, rslc_pkg::A_MSC):   next_rdata = msc;
            wrHit(regAddr, rslc_pkg::A_CTRL4): next_rdata = ctrlFour;
            wrHit(regAddr, rslc_pkg::A_DBG):   next_rdata = dbg;
            wrHit(regAddr, rslc_pkg::A_ID0):   next_rdata = {24'h000000, DEV_CODE}; // R8 R20
            wrHit(regAddr, rslc_pkg::A_ID1):   next_rdata = {24'h000000, STEP_REV}; // R8 R20
            wrHit(regAddr, rslc_pkg::A_STAT):  next_rdata = {30'h0, busLock, coreRun};
            inCcr && idx != 3'h7:               next_rdata = {24'h000000, ccr[idx]};
            inRegion:                           next_rdata = {24'h000000, regionAddr[idx]};
            inRcr:                              next_rdata = {24'h000000, rcr[idx]};
            default:                            next_rdata = 32'h0000_0000;
        endcase
    end

    // Start-up delay; no fetch or lock while held
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            regRdata        <= 32'h0000_0000;
            startCnt        <= 10'h000;
            coreRun         <= 1'b0; // R18
            fetchStart      <= 1'b0;
            fetchAddr       <= rslc_pkg::FETCH_VECTOR;
            immFromPrefetch <= 1'b0;
            busLock         <= 1'b0;
        end else begin
            regRdata   <= regRd ? next_rdata : 32'h0000_0000;
            fetchStart <= 1'b0;
            if (!coreRun) begin
                startCnt <= startCnt + 10'h001;
                if (startCnt == 10'(START_DELAY - 1)) begin
                    coreRun    <= 1'b1;
                    fetchStart <= 1'b1; // R19
                end
            end
            immFromPrefetch <= coreRun && prefetchImm; // R17
            busLock         <= coreRun && lockRaw;
        end
    end

    rslc_lock_check u_lock (
        .clk          (clk),
        .rstSync_n    (rstSync_n),
        .decValid     (decValid && coreRun),
        .opClass      (opClass),
        .lockPrefix   (lockPrefix),
        .destIsMem    (destIsMem),
        .sizePrefix   (sizePrefix),
        .code32       (code32),
        .byteOp       (byteOp),
        .fpOp         (fpOp),
        .fpExt        (fpExt),
        .numOps       (numOps),
        .noLockGlobal (ccr[rslc_pkg::CFG1_IDX][rslc_pkg::NO_LOCK_BIT]), // R13
        .regionWeak   (rcr[memRegion][rslc_pkg::WEAK_LOCK_BIT]), // R13
        .invOpcode    (invOpcode),
        .lockOut      (lockRaw),
        .opLen        (opLen),
        .opCount      (opCount)
    );

    AST_RESET_VALS: assert property (@(posedge clk)
        $rose(rstSync_n) |-> msc == rslc_pkg::MSC_RST && dbg == rslc_pkg::DBG_RST
                             && idtLim == rslc_pkg::IDT_LIM_RST
                             && ctrlFour == rslc_pkg::CTRL4_RST) // R3
        else $error("control reset values wrong");
    AST_SEG_RST: assert property (@(posedge clk)
        $rose(rstSync_n) |-> fLim == 16'hFFFF && gLim == 16'hFFFF && fSel == 16'h0) // R1
        else $error("extra segment reset wrong");
    AST_CFG4: assert property (@(posedge clk)
        $rose(rstSync_n) |-> ccr[4] == 8'h80 && ccr[1] == 8'h00 && rcr[0] == 8'h00) // R4
        else $error("config reset wrong");
    AST_ID_RO: assert property (@(posedge clk) disable iff (!rstSync_n)
        regRd && regAddr == rslc_pkg::A_ID0 |=> regRdata == {24'h0, DEV_CODE}) // R20
        else $error("identification value changed");
    AST_NO_EARLY: assert property (@(posedge clk) disable iff (!rstSync_n)
        !coreRun |-> !busLock && !fetchStart) // R18
        else $error("activity before start");
endmodule

// ==== dv/rslc_lock_observer.sv ====
// Bus-side observer that counts locked access sequences
module rslc_lock_observer (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic busLock,
    output int        lockSeqs
);
    timeunit 1ns;
    timeprecision 1ps;
    logic lockSeen;
    // A rising lock opens one indivisible sequence; a level would be counted per cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lockSeen <= 1'b0;
            lockSeqs <= 0;
        end else begin
            lockSeen <= busLock;
            if (busLock && !lockSeen) lockSeqs <= lockSeqs + 1;
        end
    end
endmodule

// ==== dv/tb_reset_state_lock_check.sv ====
// Testbench for the reset-state and lock-check block
module tb_reset_state_lock_check;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int         DELAY = 4;
    localparam logic [7:0] DEV   = 8'h3C; // Arbitrary value
    localparam logic [7:0] STEP  = 8'h12; // Arbitrary value
    logic                    clk, rst_n, regWr, regRd, decValid, lockPrefix, destIsMem;
    logic                    sizePrefix, byteOp, fpOp, fpExt, prefetchImm;
    logic                    invOpcode, busLock, immFromPrefetch, fetchStart, coreRun;
    logic                    seenInv, seenLock;
    logic [5:0]              regAddr;
    logic [31:0]             regWdata, regRdata, fetchAddr;
    logic [2:0]              memRegion;
    logic [1:0]              numOps, opCount, seenCnt;
    rslc_pkg::rslc_opclass_t opClass;
    rslc_pkg::rslc_len_t     opLen, seenLen;
    int                      fails, samplesChecked, lockSeqs;

    rslc_reset_state #(.START_DELAY(DELAY), .DEV_CODE(DEV), .STEP_REV(STEP)) i_dut (
        .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .decValid(decValid), .opClass(opClass),
        .lockPrefix(lockPrefix), .destIsMem(destIsMem), .memRegion(memRegion),
        .sizePrefix(sizePrefix), .byteOp(byteOp), .fpOp(fpOp), .fpExt(fpExt),
        .numOps(numOps), .prefetchImm(prefetchImm), .invOpcode(invOpcode),
        .busLock(busLock), .opLen(opLen), .opCount(opCount),
        .immFromPrefetch(immFromPrefetch), .fetchStart(fetchStart),
        .fetchAddr(fetchAddr), .coreRun(coreRun));
    rslc_lock_observer i_obs (.clk(clk), .rst_n(rst_n), .busLock(busLock),
        .lockSeqs(lockSeqs));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run;
        $display("Checked %0d, mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clk);
        regWr    <= 1'b0;
    endtask

    task automatic rd_check(input string name, input logic [5:0] a, input logic [31:0] e);
        @(posedge clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk);
        regRd   <= 1'b0;
        #1;
        check(name, regRdata, e);
    endtask

    // Attributes stay put after the pulse; decode ignores them without decValid
    task automatic decode(input rslc_pkg::rslc_opclass_t c, input logic lk, input logic m,
                          input logic [2:0] r, input logic [3:0] at, input logic [1:0] n);
        @(posedge clk);
        opClass <= c;
        lockPrefix <= lk;
        destIsMem <= m;
        memRegion <= r;
        {sizePrefix, byteOp, fpOp, fpExt} <= at;
        numOps <= n;
        decValid <= 1'b1;
        @(posedge clk);
        decValid <= 1'b0;
        #1;
        seenInv = invOpcode;
        seenLen = opLen;
        seenCnt = opCount;
        @(posedge clk);
        #1;
        seenLock = busLock;
    endtask

    task automatic test_startup;
        int n;
        n = 0;
        check("coreRunInReset", {31'h0, coreRun}, 32'h0);
        while (coreRun !== 1'b1 && n < 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        // Two synchroniser edges, then the start count
        check("startDelay", {31'h0, n == DELAY + 2}, 32'h1);
        check("fetchStart", {31'h0, fetchStart}, 32'h1);
        check("fetchAddr", fetchAddr, 32'hFFFF_FFF0);
        @(posedge clk);
        #1;
        check("fetchStartPulse", {31'h0, fetchStart}, 32'h0);
    endtask

    task automatic test_reset_values;
        logic [5:0]  a[11] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07,
                               6'h08, 6'h09, 6'h0A};
        logic [31:0] e[11] = '{32'h0, 32'h0, 32'h0000_FFFF, 32'h0, 32'h0, 32'h0000_FFFF,
                               32'h0, 32'h0000_03FF, 32'h6000_0010, 32'h0, 32'h0000_0400};
        for (int i = 0; i < 11; i++) rd_check("resetValue", a[i], e[i]);
        for (int i = 0; i < 7; i++) begin
            rd_check("ccr", rslc_pkg::A_CCR + 6'(i), (i == 4) ? 32'h80 : 32'h0);
        end
        for (int i = 0; i < 8; i++) begin
            rd_check("regionAddr", rslc_pkg::A_REGION + 6'(i), 32'h0);
            rd_check("rcr", rslc_pkg::A_RCR + 6'(i), 32'h0);
        end
        rd_check("ident0", rslc_pkg::A_ID0, {24'h0, DEV});
        rd_check("ident1", rslc_pkg::A_ID1, {24'h0, STEP});
        reg_write(rslc_pkg::A_ID0, 32'hFFFF_FFFF);
        reg_write(rslc_pkg::A_ID1, 32'hFFFF_FFFF);
        rd_check("ident0Wr", rslc_pkg::A_ID0, {24'h0, DEV});
        rd_check("ident1Wr", rslc_pkg::A_ID1, {24'h0, STEP});
        rd_check("unmapped", 6'h0E, 32'h0);
    endtask

    task automatic test_lock_groups;
        int base;
        base = lockSeqs;
        for (int c = 0; c < 5; c++) begin
            for (int m = 0; m < 2; m++) begin
                decode(rslc_pkg::rslc_opclass_t'(c), 1'b1, m[0], 3'h0, 4'h0, 2'h2);
                check("invOpcode", {31'h0, seenInv}, {31'h0, c == 4 || m == 0});
                check("busLock", {31'h0, seenLock}, {31'h0, c < 4 && m == 1});
            end
        end
        decode(rslc_pkg::RSLC_OP_OTHER, 1'b0, 1'b1, 3'h0, 4'h0, 2'h0);
        check("invNoLock", {31'h0, seenInv}, 32'h0);
        check("lockSeqs", 32'(lockSeqs - base), 32'd4);
    endtask

    task automatic test_weak_lock;
        reg_write(rslc_pkg::A_CCR + 6'h01, 32'h10);
        decode(rslc_pkg::RSLC_OP_BINARY, 1'b1, 1'b1, 3'h0, 4'h0, 2'h2);
        check("globalWeak", {30'h0, seenLock, seenInv}, 32'h0);
        reg_write(rslc_pkg::A_CCR + 6'h01, 32'h0);
        reg_write(rslc_pkg::A_RCR + 6'h03, 32'h40);
        decode(rslc_pkg::RSLC_OP_XCHG, 1'b1, 1'b1, 3'h3, 4'h0, 2'h2);
        check("regionWeak", {31'h0, seenLock}, 32'h0);
        decode(rslc_pkg::RSLC_OP_XCHG, 1'b1, 1'b1, 3'h2, 4'h0, 2'h2);
        check("otherRegion", {31'h0, seenLock}, 32'h1);
        reg_write(rslc_pkg::A_RCR + 6'h03, 32'h0);
    endtask

    task automatic test_length;
        logic [3:0] at[7] = '{4'h0, 4'h8, 4'h4, 4'h2, 4'h3, 4'h0, 4'h8};
        rslc_pkg::rslc_len_t e[7] = '{rslc_pkg::RSLC_LEN_16, rslc_pkg::RSLC_LEN_32,
            rslc_pkg::RSLC_LEN_8, rslc_pkg::RSLC_LEN_64, rslc_pkg::RSLC_LEN_80,
            rslc_pkg::RSLC_LEN_32, rslc_pkg::RSLC_LEN_16};
        for (int i = 0; i < 7; i++) begin
            // Last two entries run as 32-bit code
            if (i == 5) reg_write(rslc_pkg::A_MSC, 32'h6000_0011);
            decode(rslc_pkg::RSLC_OP_OTHER, 1'b0, 1'b0, 3'h0, at[i], 2'(i));
            check("opLen", {29'h0, seenLen}, {29'h0, e[i]});
            check("opCount", {30'h0, seenCnt}, {30'h0, 2'(i)});
        end
    endtask

    task automatic test_immediate;
        @(posedge clk);
        prefetchImm <= 1'b1;
        @(posedge clk);
        prefetchImm <= 1'b0;
        #1;
        check("immFetch", {31'h0, immFromPrefetch}, 32'h1);
        @(posedge clk);
        #1;
        check("immIdle", {31'h0, immFromPrefetch}, 32'h0);
    endtask

    // Second reset in mid-run must restore what software changed
    task automatic test_mid_reset;
        reg_write(rslc_pkg::A_CCR + 6'h04, 32'h00);
        reg_write(rslc_pkg::A_REGION + 6'h02, 32'hA5);
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        #1;
        test_startup();
        rd_check("mscAgain", rslc_pkg::A_MSC, 32'h6000_0010);
        rd_check("cfg4Again", rslc_pkg::A_CCR + 6'h04, 32'h80);
        rd_check("regionAgain", rslc_pkg::A_REGION + 6'h02, 32'h0);
        rd_check("status", rslc_pkg::A_STAT, 32'h1);
    endtask

    // Whole run is well under two thousand cycles
    initial begin
        #100us;
        fails++;
        complete_run();
    end

    initial begin
        {rst_n, regWr, regRd, decValid, lockPrefix, destIsMem} = '0;
        {sizePrefix, byteOp, fpOp, fpExt, prefetchImm} = '0;
        {regAddr, regWdata, memRegion, numOps} = '0;
        opClass = rslc_pkg::RSLC_OP_OTHER;
        fails = 0;
        samplesChecked = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        test_startup();
        test_reset_values();
        test_lock_groups();
        test_weak_lock();
        test_length();
        test_immediate();
        test_mid_reset();
        complete_run();
    end
endmodule
